/* inc/twmds_pkg.sv */
package twmds_pkg;

  // Time base and SCL-low timeout
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned TIMEOUT_MS     = 30;
  localparam int unsigned TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;

  // Address decode: seven-bit address is {ADDR_BASE, variant}
  localparam logic [3:0] ADDR_BASE     = 4'he;
  localparam logic [7:0] BCAST_WR_ADDR = 8'h00;
  localparam logic [7:0] BCAST_RD_ADDR = 8'h01;
  localparam logic [7:0] GC_RESET_CMD  = 8'h06;

  // Bit counter positions within one byte frame
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;

  // Devices per bus, register file defaults
  localparam int unsigned MAX_DEVICES = 8;
  localparam int unsigned NREG_DEF    = 4;
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [3:0]  SLOT_LAST   = 4'h8;

  // Synchronised bus levels and conditions
  typedef struct packed {
    logic scl;
    logic sda;
    logic sclRise;
    logic sclFall;
    logic start;
    logic stop;
  } twmds_bus_t;

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_ADDR  = 8'h02,
    S_PTR   = 8'h04,
    S_GCALL = 8'h08,
    S_WDATA = 8'h10,
    S_READ  = 8'h20,
    S_MREAD = 8'h40,
    S_HOLD  = 8'h80
  } twmds_state_t;

endpackage

/* hdl/twmds_line_sync.sv */
`timescale 1ns/1ns
module twmds_line_sync (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 sclPin,
  input  wire logic                 sdaPin,
  output twmds_pkg::twmds_bus_t     bus
);

  logic sclM_q;
  logic sclS_q;
  logic sclP_q;
  logic sdaM_q;
  logic sdaS_q;
  logic sdaP_q;

  // Two-flop synchronisers, then one delayed copy for edges; idle bus is high
  // idle bus high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclM_q <= 1'b1;
      sclS_q <= 1'b1;
      sclP_q <= 1'b1;
      sdaM_q <= 1'b1;
      sdaS_q <= 1'b1;
      sdaP_q <= 1'b1;
    end else begin
      sclM_q <= sclPin;
      sclS_q <= sclM_q;
      sclP_q <= sclS_q;
      sdaM_q <= sdaPin;
      sdaS_q <= sdaM_q;
      sdaP_q <= sdaS_q;
    end
  end

  // Conditions only qualified with SCL high on both samples
  always_comb begin
    bus.scl     = sclS_q;
    bus.sda     = sdaS_q;
    bus.sclRise = sclS_q & ~sclP_q;
    bus.sclFall = ~sclS_q & sclP_q;
    bus.start   = sclS_q & sclP_q & sdaP_q & ~sdaS_q;
    bus.stop    = sclS_q & sclP_q & ~sdaP_q & sdaS_q;
  end

endmodule

/* hdl/twmds_slave.sv */
`timescale 1ns/1ns
// What this block does
// - Reset interface after SCL low 30 ms
// - On timeout release SDA, await START
// - Decode 00000000 and 00000001 broadcast addresses
// - Acknowledge broadcast address, then run transaction
// - Acknowledge broadcast pointer byte, latch it unless it is the 00000110 reset command
// - Store and acknowledge broadcast data byte
// - Drive read byte only in own slot
// - Not-acknowledge stops all later slot driving
// - Eight devices maximum, distinct variants
// - Both lines high means bus idle
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - Repeated START or STOP ends transfer
// - No byte count limit per transfer
// - Receiver holds SDA low through ninth pulse, except for bytes after the reset command
// - Own address 1110 plus variant bits
// - First written byte is kept pointer
module twmds_slave #(
  parameter int unsigned VARIANT     = 0,
  parameter int unsigned NREG        = twmds_pkg::NREG_DEF,
  parameter int unsigned TIMEOUT_CYC = twmds_pkg::TIMEOUT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic            regWrStrobe,
  output logic [7:0]      regWrAddr,
  output logic [7:0]      regWrData,
  output logic            gcResetPulse
);

  localparam int unsigned IW = (NREG > 1) ? $clog2(NREG) : 1;
  localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TOUT_MAX = TW'(TIMEOUT_CYC);
  localparam logic [7:0] OWN_WR = {twmds_pkg::ADDR_BASE, 3'(VARIANT), 1'b0};
  localparam logic [7:0] OWN_RD = {twmds_pkg::ADDR_BASE, 3'(VARIANT), 1'b1};
  localparam logic [3:0] MY_SLOT = 4'(VARIANT);

  if (VARIANT >= twmds_pkg::MAX_DEVICES || NREG < 2 || NREG > 256 || TIMEOUT_CYC < 2) begin
    $error("twmds_slave: unsupported parameter value");
  end

  twmds_pkg::twmds_bus_t  ev;
  twmds_pkg::twmds_state_t state_q;
  logic [3:0]             bitCnt_q;
  logic [7:0]             shift_q;
  logic [7:0]             ptr_q;
  logic [7:0]             txByte_q;
  logic [3:0]             slot_q;
  logic                   ackDrive_q;
  logic                   txDrive_q;
  logic [TW-1:0]          toutCnt_q;
  logic [7:0]             regs_q [NREG];
  logic                   toutHit;
  logic                   byteDone;
  logic                   ackRise;
  logic                   ackEnd;
  logic                   txMode;
  logic                   txActive;
  logic                   masterNack;

  twmds_line_sync u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .sclPin  (sclIn),
    .sdaPin  (sdaIn),
    .bus     (ev)
  );

  // Register read with out-of-range pointers returning zero
  // Nine-bit compare so a full 256-entry file is still reachable
  function automatic logic [7:0] rdByte(input logic [7:0] p);
    if (9'(p) < 9'(NREG))
      return regs_q[p[IW-1:0]];
    return 8'h00;
  endfunction

  // Frame strobes derived from the bit counter
  assign byteDone   = ev.sclFall && bitCnt_q == twmds_pkg::BIT_ACK;
  assign ackRise    = ev.sclRise && bitCnt_q == twmds_pkg::BIT_ACK;
  assign ackEnd     = ev.sclFall && bitCnt_q == twmds_pkg::BIT_END;
  assign txMode     = state_q == twmds_pkg::S_READ || state_q == twmds_pkg::S_MREAD;
  assign txActive   = state_q == twmds_pkg::S_READ ||
                      (state_q == twmds_pkg::S_MREAD && slot_q == MY_SLOT);
  assign masterNack = ackRise && txMode && ev.sda;
  // Open drain: only ever pulls low
  assign sdaOut     = 1'b0;
  assign sdaOe      = ackDrive_q | txDrive_q;

  // counter clears on any SCL high, so a 1 kHz SCL never trips it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      toutCnt_q <= '0;
    else if (ev.scl)
      toutCnt_q <= '0;
    else if (toutCnt_q != TOUT_MAX)
      toutCnt_q <= toutCnt_q + TW'(1);
  end
  assign toutHit = !ev.scl && toutCnt_q == TOUT_MAX - TW'(1);

  // Bit counter and receive shifter; bytes are MSB first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_q <= 4'h0;
      shift_q  <= 8'h00;
    end else if (ev.start || ev.stop || toutHit) begin
      bitCnt_q <= 4'h0;
    end else if (ev.sclRise && bitCnt_q < twmds_pkg::BIT_ACK) begin
      shift_q  <= {shift_q[6:0], ev.sda};
      bitCnt_q <= bitCnt_q + 4'h1;
    end else if (ackRise) begin
      bitCnt_q <= twmds_pkg::BIT_END;
    end else if (ackEnd) begin
      bitCnt_q <= 4'h0;
    end
  end

  // Transaction sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= twmds_pkg::S_IDLE;
    end else if (toutHit) begin
      state_q <= twmds_pkg::S_IDLE;
    end else if (ev.stop) begin
      state_q <= twmds_pkg::S_IDLE;
    end else if (ev.start) begin
      state_q <= twmds_pkg::S_ADDR;
    end else if (masterNack) begin
      state_q <= twmds_pkg::S_IDLE;
    end else if (byteDone) begin
      case (state_q)
        twmds_pkg::S_ADDR: begin
          if (shift_q == OWN_WR)
            state_q <= twmds_pkg::S_PTR;
          else if (shift_q == OWN_RD)
            state_q <= twmds_pkg::S_READ;
          else if (shift_q == twmds_pkg::BCAST_WR_ADDR)
            state_q <= twmds_pkg::S_GCALL;
          else if (shift_q == twmds_pkg::BCAST_RD_ADDR)
            state_q <= twmds_pkg::S_MREAD;
          else
            state_q <= twmds_pkg::S_IDLE;
        end
        twmds_pkg::S_PTR: state_q <= twmds_pkg::S_WDATA;
        twmds_pkg::S_GCALL: begin
          if (shift_q == twmds_pkg::GC_RESET_CMD)
            state_q <= twmds_pkg::S_HOLD;
          else
            state_q <= twmds_pkg::S_WDATA;
        end
        default: state_q <= state_q;
      endcase
    end
  end

  // Pointer and read slot tracking
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q  <= 8'h00;
      slot_q <= 4'h0;
    end else if (byteDone && state_q == twmds_pkg::S_ADDR) begin
      slot_q <= 4'h0;
    end else if (byteDone && (state_q == twmds_pkg::S_PTR ||
                 (state_q == twmds_pkg::S_GCALL && shift_q != twmds_pkg::GC_RESET_CMD))) begin
      ptr_q <= shift_q;
    // dummy slots still advance; own address ack is no slot
    end else if (ackRise && state_q == twmds_pkg::S_MREAD && !ev.sda && !ackDrive_q &&
                 slot_q != twmds_pkg::SLOT_LAST) begin
      slot_q <= slot_q + 4'h1;
    end
  end

  // Register file; pointer does not advance, extra bytes rewrite it
  // no byte count limit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NREG; i++)
        regs_q[i] <= twmds_pkg::REG_RESET;
      regWrStrobe  <= 1'b0;
      regWrAddr    <= 8'h00;
      regWrData    <= 8'h00;
      gcResetPulse <= 1'b0;
    end else begin
      regWrStrobe  <= 1'b0;
      gcResetPulse <= 1'b0;
      if (byteDone && state_q == twmds_pkg::S_WDATA) begin
        if (9'(ptr_q) < 9'(NREG))
          regs_q[ptr_q[IW-1:0]] <= shift_q;
        regWrStrobe <= 1'b1;
        regWrAddr   <= ptr_q;
        regWrData   <= shift_q;
      end else if (byteDone && state_q == twmds_pkg::S_GCALL &&
                   shift_q == twmds_pkg::GC_RESET_CMD) begin
        for (int i = 0; i < NREG; i++)
          regs_q[i] <= twmds_pkg::REG_RESET;
        gcResetPulse <= 1'b1;
      end
    end
  end

  // Acknowledge drive for every received byte while addressed, except bytes after the reset command (S_HOLD)
  // low through ninth pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      ackDrive_q <= 1'b0;
    else if (toutHit || ev.start || ev.stop || ackEnd)
      ackDrive_q <= 1'b0;
    else if (byteDone) begin
      case (state_q)
        twmds_pkg::S_ADDR:
          ackDrive_q <= shift_q == OWN_WR || shift_q == OWN_RD ||
                        shift_q == twmds_pkg::BCAST_WR_ADDR ||
                        shift_q == twmds_pkg::BCAST_RD_ADDR;
        twmds_pkg::S_PTR,
        twmds_pkg::S_GCALL,
        twmds_pkg::S_WDATA: ackDrive_q <= 1'b1;
        default: ackDrive_q <= 1'b0;
      endcase
    end
  end

  // Transmit byte loaded on address and after each acked byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      txByte_q <= 8'h00;
    else if ((byteDone && state_q == twmds_pkg::S_ADDR) || (ackRise && txMode))
      txByte_q <= rdByte(ptr_q);
  end

  // Data bits change only while SCL is low
  // drive only own slot
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      txDrive_q <= 1'b0;
    else if (toutHit || ev.start || ev.stop || masterNack)
      txDrive_q <= 1'b0;
    else if (ackEnd)
      txDrive_q <= txActive && !txByte_q[7];
    else if (ev.sclFall && bitCnt_q != 4'h0 && bitCnt_q < twmds_pkg::BIT_ACK)
      txDrive_q <= txActive && !txByte_q[3'(4'h7 - bitCnt_q)];
    else if (byteDone)
      txDrive_q <= 1'b0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  startArm_a: assert property (ev.start && !toutHit |=> state_q == twmds_pkg::S_ADDR)
    else $error("START did not arm address phase");
  stopIdle_a: assert property (ev.stop && !ev.start && !toutHit |=> state_q == twmds_pkg::S_IDLE && !sdaOe)
    else $error("STOP did not return to idle");
  timeoutRel_a: assert property (toutHit |=> !sdaOe && state_q == twmds_pkg::S_IDLE)
    else $error("timeout did not release bus");
  timeoutCnt_a: assert property (!ev.scl && toutCnt_q == TOUT_MAX - TW'(2) ##1 !ev.scl |-> toutHit)
    else $error("timeout not reached at count");
  ackHold_a: assert property (ackDrive_q && !ev.sclFall && !ev.start && !ev.stop && !toutHit |=> ackDrive_q)
    else $error("acknowledge dropped early");
  slotOnly_a: assert property (txDrive_q && state_q == twmds_pkg::S_MREAD |-> slot_q == MY_SLOT)
    else $error("drove outside own slot");
  nackStop_a: assert property (masterNack && !ev.start && !ev.stop |=> !txDrive_q ##1 state_q == twmds_pkg::S_IDLE)
    else $error("kept driving after not-acknowledge");
  bcastAck_a: assert property (byteDone && state_q == twmds_pkg::S_ADDR && shift_q[7:1] == 7'h00 |=> ackDrive_q)
    else $error("broadcast address not acknowledged");
  ptrLatch_a: assert property (byteDone && state_q == twmds_pkg::S_PTR |=> ptr_q == $past(shift_q) && ackDrive_q)
    else $error("pointer not latched");
  dataWrite_a: assert property (byteDone && state_q == twmds_pkg::S_WDATA |=> regWrStrobe && regWrData == $past(shift_q))
    else $error("data byte not stored");
  slotHold_a: assert property (ackDrive_q && state_q == twmds_pkg::S_MREAD |=> $stable(slot_q))
    else $error("address acknowledge advanced the slot");

  bcastWr_c:  cover property (byteDone && state_q == twmds_pkg::S_WDATA);
  slotDrv_c:  cover property (txDrive_q && state_q == twmds_pkg::S_MREAD);
  timeout_c:  cover property (toutHit);
  gcReset_c:  cover property (gcResetPulse);

endmodule

/* tb/twmds_master_model.sv */
`timescale 1ns/1ns
// Bus master stand-in: makes SCL, pulls SDA open drain
module twmds_master_model (
  output logic      sclPin,
  output logic      sdaDrv,
  input  wire logic sdaLine
);
  initial begin
    sclPin = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic start;
    sdaDrv = 1'b1;
    #120 sclPin = 1'b1;
    #200 sdaDrv = 1'b0;
    #200 sclPin = 1'b0;
    #120;
  endtask
  task automatic stop;
    sdaDrv = 1'b0;
    #120 sclPin = 1'b1;
    #200 sdaDrv = 1'b1;
    #200;
  endtask
  // Steady 320 ns bit
  // SDA moves 3 clk away from either SCL edge so no false START
  task automatic clkBit(input logic b, output logic s);
    sdaDrv = b;
    #120 sclPin = 1'b1;
    #80 s = sdaLine;
    sclPin = 1'b0;
    #120;
  endtask
  // MSB first, then the receiver's ack bit
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clkBit(d[i], s);
    clkBit(1'b1, s);
    ack = ~s;
  endtask
  task automatic rdByte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clkBit(1'b1, d[i]);
    clkBit(~ack, s);
  endtask
endmodule

/* tb/twmds_slave_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); \
  end \
end
module twmds_slave_tb;
  logic       clk = 1'b0;
  logic       reset_n;
  logic       sclPin, sdaDrv, sdaLine, ack;
  logic       uutOut, uutOe, peerOut, peerOe, uutStb, peerStb, uutGc;
  logic [7:0] uutAddr, uutData, lastAddr, lastData;
  int         failures = 0, checks_done = 0, uutWr = 0, peerWr = 0, gcSeen = 0;

  always #20 clk = ~clk;
  // Open-drain SDA with pull-up
  assign sdaLine = sdaDrv & (uutOe ? uutOut : 1'b1) & (peerOe ? peerOut : 1'b1);

  twmds_master_model master (.sclPin(sclPin), .sdaDrv(sdaDrv), .sdaLine(sdaLine));
  // Distinct variants 2, 0
  // Short timeout keeps the run brief
  twmds_slave #(.VARIANT(2), .TIMEOUT_CYC(200)) uut (
    .clk(clk), .reset_n(reset_n), .sclIn(sclPin), .sdaIn(sdaLine),
    .sdaOut(uutOut), .sdaOe(uutOe), .regWrStrobe(uutStb), .regWrAddr(uutAddr),
    .regWrData(uutData), .gcResetPulse(uutGc));
  twmds_slave #(.VARIANT(0), .TIMEOUT_CYC(200)) peer (
    .clk(clk), .reset_n(reset_n), .sclIn(sclPin), .sdaIn(sdaLine),
    .sdaOut(peerOut), .sdaOe(peerOe), .regWrStrobe(peerStb), .regWrAddr(),
    .regWrData(), .gcResetPulse());

  // Count strobes; keep the last write seen
  always @(posedge clk) begin
    if (uutStb === 1'b1) begin
      uutWr++;
      lastAddr = uutAddr;
      lastData = uutData;
    end
    if (peerStb === 1'b1) peerWr++;
    if (uutGc === 1'b1) gcSeen++;
  end

  task automatic sendChk(input logic [7:0] b, input logic expAck, input string nm);
    master.wrByte(b, ack);
    `CHK(nm, expAck, ack)
  endtask
  task automatic readChk(input logic a, input logic [7:0] exp, input string nm);
    logic [7:0] d;
    master.rdByte(a, d);
    `CHK(nm, exp, d)
  endtask

  task automatic t_bcast_wr;
    master.start();
    sendChk(8'h00, 1'b1, "bcast wr addr");
    sendChk(8'h01, 1'b1, "bcast ptr");
    sendChk(8'ha5, 1'b1, "bcast data");
    master.stop();
    `CHK("uut writes", 1, uutWr)
    `CHK("peer writes", 1, peerWr)
    `CHK("bcast addr", 8'h01, lastAddr)
    `CHK("bcast byte", 8'ha5, lastData)
    $display("done bcast write");
  endtask

  task automatic t_own;
    master.start();
    sendChk(8'he4, 1'b1, "own wr addr");
    sendChk(8'h01, 1'b1, "own ptr");
    sendChk(8'h3c, 1'b1, "own data");
    `CHK("own wr data", 8'h3c, lastData)
    master.start(); // repeated START
    sendChk(8'he5, 1'b1, "own rd addr");
    readChk(1'b1, 8'h3c, "own rd 1");
    readChk(1'b0, 8'h3c, "own rd 2");
    master.start();
    sendChk(8'he6, 1'b0, "other variant");
    master.stop();
    $display("done own access");
  endtask

  task automatic t_bcast_rd;
    master.start(); // pointer already set
    sendChk(8'h01, 1'b1, "bcast rd addr");
    readChk(1'b1, 8'ha5, "slot 0");
    readChk(1'b1, 8'hff, "slot 1 gap");
    readChk(1'b0, 8'h3c, "slot 2");
    master.start();
    sendChk(8'h01, 1'b1, "bcast rd again");
    readChk(1'b0, 8'ha5, "slot 0 nack");
    readChk(1'b1, 8'hff, "slot 1 after nack");
    readChk(1'b1, 8'hff, "slot 2 after nack");
    master.stop();
    $display("done bcast read");
  endtask

  task automatic t_gcall_timeout;
    master.start();
    sendChk(8'h00, 1'b1, "gcall addr");
    sendChk(8'h06, 1'b1, "gcall cmd");
    master.stop();
    `CHK("gcall pulse", 1, gcSeen)
    master.start();
    sendChk(8'he5, 1'b1, "rd after gcall");
    // Register now zero, so the device holds SDA low
    #40;
    `CHK("tx bit low", 1'b0, sdaLine)
    #10000;
    `CHK("released", 1'b0, uutOe)
    `CHK("line high", 1'b1, sdaLine)
    sendChk(8'he4, 1'b0, "no START yet");
    master.stop();
    $display("done gcall and timeout");
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Master steps start 1 ns after an edge and stay on that phase
  initial begin
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_bcast_wr();
    t_own();
    t_bcast_rd();
    t_gcall_timeout();
    report_and_stop();
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule
